// >>> rtl/gdac_ctrl.sv
// two-wire slave control of a 24-channel gamma/common-voltage code block with two nonvolatile banks
// assumes an external master on scl/sda, an open-drain sda wire resolved outside, and sys_clk well above scl
// Summary of operation
// - answer address 111010 plus the strap pin level as lowest bit
// - slave only; the clock line is an input and never driven
// - sample address on clock rise, last bit is read/write, ack in ninth clock
// - data changes while clock high decode as start (fall) or stop (rise)
// - every byte after the address is eight bits plus one ack bit
// - master code 00001xxx after start is accepted and never acknowledged
// - master code enables high-speed mode, kept across repeated starts, left at stop
// - general call followed by 06h is acknowledged and resets the block except pin sampling and the nonvolatile store
// - general-call address always acknowledged, other general-call data bytes refused
// - at reset load each channel from its bank, mid-scale if never programmed
// - holding register per channel separate from its output latch
// - write with data bit 15 set moves the register to output after bit sixteen
// - bit 15 clear updates holding only; a later set transfers all channels
// - bank-select low picks bank zero, high picks bank one
// - any bank-select change reloads all registers and outputs from the new bank
// - at reset the bank-select level picks the active bank
// - acquire commands read the bank that bank-select currently picks
// - pointer 10 plus valid channel starts a general acquire; invalid channels refused
// - single acquire reloads only the addressed channel register and output
// - each bank allows sixteen programming operations per channel
// - hold a 10-bit code for 22 gamma and 2 common-voltage channels
// - pointer 01 plus channel starts a single-channel acquire
// - general acquire lands all channels about 750 microseconds after command
// - register write is pointer 00, msb then lsb byte; early end leaves register unchanged
`timescale 1ns/1ps
`include "gdac_params.svh"
module gdac_ctrl
	import gdac_pkg::*;
#(
	parameter int N_CH = `GDAC_NUM_CH,
	parameter int ACQ_ALL_CYC = `GDAC_ACQ_ALL_CYC,
	parameter int ACQ_ONE_CYC = `GDAC_ACQ_ONE_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// two-wire bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// strap and bank pins
	input wire logic addr_strap_pin,
	input wire logic bank_select_pin,
	// nonvolatile programming port
	input gdac_nvm_wr_s nvm_wr,
	output logic nvm_wr_refused,
	// channel outputs and status
	output logic [N_CH-1:0][`GDAC_CODE_W-1:0] dac_code,
	output logic hs_mode,
	output logic acq_busy
);
	localparam int S_SCL = 0;
	localparam int S_SDA = 1;
	localparam int S_STRAP = 2;
	localparam int S_BANK = 3;
	localparam logic [3:0] SYNC_INIT = 4'h3;
	localparam int WW = `GDAC_WAIT_W;
	localparam logic [WW-1:0] ALL_WAIT = WW'(ACQ_ALL_CYC - 1);
	localparam logic [WW-1:0] ONE_WAIT = WW'(ACQ_ONE_CYC - 1);
	localparam logic [`GDAC_PTR_W-1:0] LAST_CH = `GDAC_PTR_W'(N_CH - 1);

	if (N_CH < 1 || N_CH > 63 || ACQ_ALL_CYC < 1 || ACQ_ONE_CYC < 1 ||
		ACQ_ALL_CYC >= (1 << WW) || ACQ_ONE_CYC >= (1 << WW)) begin : g_bad_param
		$error("gdac_ctrl: parameter out of range");
	end

	// pin synchronisers: three stages, level taken when stages two and three agree
	logic [3:0] pin_raw;
	logic [3:0] s1_q, s2_q, s3_q, filt_q, filt_d;
	assign pin_raw = {bank_select_pin, addr_strap_pin, sda_in, scl_in}; // clock pin only sampled
	for (genvar i = 0; i < 4; i++) begin : g_sync
		always_comb begin
			filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_q[i];
		end
		always_ff @(posedge sys_clk) begin
			if (rst) begin
				s1_q[i] <= SYNC_INIT[i];
				s2_q[i] <= SYNC_INIT[i];
				s3_q[i] <= SYNC_INIT[i];
				filt_q[i] <= SYNC_INIT[i];
			end else begin
				s1_q[i] <= pin_raw[i];
				s2_q[i] <= s1_q[i];
				s3_q[i] <= s2_q[i];
				filt_q[i] <= filt_d[i];
			end
		end
	end

	// bus events from the filtered levels
	logic scl_rise, scl_fall, start_det, stop_det, bank_chg;
	assign scl_rise = filt_d[S_SCL] & ~filt_q[S_SCL];
	assign scl_fall = ~filt_d[S_SCL] & filt_q[S_SCL];
	assign start_det = filt_q[S_SCL] & filt_d[S_SCL] & filt_q[S_SDA] & ~filt_d[S_SDA];
	assign stop_det = filt_q[S_SCL] & filt_d[S_SCL] & ~filt_q[S_SDA] & filt_d[S_SDA];
	assign bank_chg = filt_d[S_BANK] ^ filt_q[S_BANK];

	// receive state
	gdac_bus_e bus_q, bus_d;
	logic [7:0] shift_q, shift_d, msb_q, msb_d;
	logic [3:0] cnt_q, cnt_d;
	logic ack_ph_q, ack_ph_d, drive_q, drive_d, hs_q, hs_d;
	logic gc_arm_q, gc_arm_d, gc_rst_q, gc_rst_d;
	logic [`GDAC_PTR_W-1:0] ptr_q, ptr_d;
	logic byte_done, addr_hit, ptr_ok, soft_rst;
	logic evt_wr, evt_xfer, evt_all, evt_one;

	assign soft_rst = rst | gc_rst_q;
	assign byte_done = scl_fall & ~ack_ph_q & (cnt_q == `GDAC_BYTE_BITS) & (bus_q != ST_IDLE);
	assign addr_hit = (shift_q[7:1] == {`GDAC_ADDR_HI, filt_q[S_STRAP]});
	assign ptr_ok = int'(shift_q[5:0]) < N_CH;

	// receive next-state: bit shifting, ack decision and command decode
	always_comb begin
		bus_d = bus_q;
		shift_d = shift_q;
		msb_d = msb_q;
		cnt_d = cnt_q;
		ack_ph_d = ack_ph_q;
		drive_d = drive_q;
		hs_d = hs_q;
		gc_arm_d = gc_arm_q;
		gc_rst_d = 1'b0;
		ptr_d = ptr_q;
		evt_wr = 1'b0;
		evt_xfer = 1'b0;
		evt_all = 1'b0;
		evt_one = 1'b0;
		if (stop_det) begin
			bus_d = ST_IDLE;
			cnt_d = 4'h0;
			ack_ph_d = 1'b0;
			drive_d = 1'b0;
			gc_arm_d = 1'b0;
			hs_d = 1'b0;
		end else if (start_det) begin
			bus_d = ST_ADDR; // high-speed mode survives a repeated start
			cnt_d = 4'h0;
			ack_ph_d = 1'b0;
			drive_d = 1'b0;
			gc_arm_d = 1'b0;
		end else if (bus_q != ST_IDLE) begin
			if (scl_rise && !ack_ph_q && cnt_q < `GDAC_BYTE_BITS) begin
				shift_d = {shift_q[6:0], filt_d[S_SDA]}; // sample on rising clock
				cnt_d = cnt_q + 4'h1; // eight data bits per byte
			end
			if (scl_fall && ack_ph_q) begin
				ack_ph_d = 1'b0; // ninth clock over, release the data line
				drive_d = 1'b0;
				cnt_d = 4'h0;
				gc_rst_d = gc_arm_q;
				gc_arm_d = 1'b0;
			end else if (byte_done) begin
				ack_ph_d = 1'b1;
				case (bus_q)
					ST_ADDR: begin
						if (shift_q[7:3] == `GDAC_HS_CODE) begin
							hs_d = 1'b1; // master code, left unanswered
							bus_d = ST_SKIP;
						end else if (shift_q == `GDAC_GCALL_ADDR) begin
							drive_d = 1'b1;
							bus_d = ST_GCALL;
						end else if (addr_hit && !shift_q[0]) begin
							drive_d = 1'b1;
							bus_d = ST_PTR;
						end else begin
							bus_d = ST_SKIP;
						end
					end
					ST_PTR: begin
						ptr_d = shift_q[5:0];
						bus_d = ST_SKIP;
						if (ptr_ok) begin
							case (shift_q[7:6])
								`GDAC_CMD_WRITE: begin
									drive_d = 1'b1;
									bus_d = ST_MSB;
								end
								`GDAC_CMD_ALL: begin
									drive_d = 1'b1;
									evt_all = 1'b1;
								end
								`GDAC_CMD_ONE: begin
									drive_d = 1'b1;
									evt_one = 1'b1;
								end
								default: begin
									drive_d = 1'b0;
								end
							endcase
						end
					end
					ST_MSB: begin
						msb_d = shift_q;
						drive_d = 1'b1;
						bus_d = ST_LSB;
					end
					ST_LSB: begin
						drive_d = 1'b1;
						evt_wr = (msb_q[7:6] != `GDAC_NVM_TAG); // loads only after the second byte
						evt_xfer = evt_wr & msb_q[`GDAC_XFER_BIT];
						ptr_d = ptr_q + `GDAC_PTR_W'(1);
						bus_d = (ptr_q == LAST_CH) ? ST_SKIP : ST_MSB;
					end
					ST_GCALL: begin
						drive_d = (shift_q == `GDAC_GCALL_RESET);
						gc_arm_d = drive_d;
						bus_d = ST_SKIP;
					end
					default: begin
						drive_d = 1'b0;
						bus_d = ST_SKIP;
					end
				endcase
			end
		end
	end

	// receive registers; a general-call reset clears all but the pin sampling and the nonvolatile store
	always_ff @(posedge sys_clk) begin
		if (soft_rst) begin
			bus_q <= ST_IDLE;
			shift_q <= 8'h00;
			msb_q <= 8'h00;
			cnt_q <= 4'h0;
			ack_ph_q <= 1'b0;
			drive_q <= 1'b0;
			hs_q <= 1'b0;
			gc_arm_q <= 1'b0;
			gc_rst_q <= 1'b0;
			ptr_q <= '0;
		end else begin
			bus_q <= bus_d;
			shift_q <= shift_d;
			msb_q <= msb_d;
			cnt_q <= cnt_d;
			ack_ph_q <= ack_ph_d;
			drive_q <= drive_d;
			hs_q <= hs_d;
			gc_arm_q <= gc_arm_d;
			gc_rst_q <= gc_rst_d;
			ptr_q <= ptr_d;
		end
	end

	// open-drain data line: only ever pulled low
	assign sda_out = 1'b0;
	assign sda_oe = drive_q;
	assign hs_mode = hs_q;

	// channel state: holding registers, output latches, acquire sequencer
	logic [N_CH-1:0][`GDAC_CODE_W-1:0] hold_q, hold_d, out_q, out_d;
	gdac_acq_e acq_q, acq_d;
	logic acq_all_q, acq_all_d;
	logic [`GDAC_PTR_W-1:0] acq_ch_q, acq_ch_d;
	logic [WW-1:0] wait_q, wait_d;
	logic rd_en;
	gdac_nvm_rd_s rd_word;
	logic [`GDAC_CODE_W-1:0] load_code;

	assign rd_en = (acq_q == ACQ_READ);
	assign load_code = rd_word.prog ? rd_word.data : `GDAC_MID_CODE;

	always_comb begin
		hold_d = hold_q;
		out_d = out_q;
		acq_d = acq_q;
		acq_all_d = acq_all_q;
		acq_ch_d = acq_ch_q;
		wait_d = wait_q;
		if (evt_wr) begin
			hold_d[ptr_q] = {msb_q[1:0], shift_q}; // holding only, output untouched
		end
		if (evt_xfer) begin
			out_d = hold_d; // every channel at once, new word included
		end
		case (acq_q)
			ACQ_IDLE: begin
				if (evt_all) begin
					acq_d = ACQ_WAIT;
					acq_all_d = 1'b1;
					acq_ch_d = '0;
					wait_d = ALL_WAIT;
				end else if (evt_one) begin
					acq_d = ACQ_WAIT;
					acq_all_d = 1'b0;
					acq_ch_d = ptr_d;
					wait_d = ONE_WAIT;
				end
			end
			ACQ_WAIT: begin
				if (wait_q == '0) begin
					acq_d = ACQ_READ;
				end else begin
					wait_d = wait_q - WW'(1);
				end
			end
			ACQ_READ: begin
				acq_d = ACQ_LOAD;
			end
			ACQ_LOAD: begin
				hold_d[acq_ch_q] = load_code;
				out_d[acq_ch_q] = load_code;
				if (acq_all_q && acq_ch_q != LAST_CH) begin
					acq_ch_d = acq_ch_q + `GDAC_PTR_W'(1);
					acq_d = ACQ_READ;
				end else begin
					acq_d = ACQ_IDLE;
				end
			end
			default: begin
				acq_d = ACQ_IDLE;
			end
		endcase
		if (bank_chg) begin
			acq_d = ACQ_READ; // restart a full reload from the new bank
			acq_all_d = 1'b1;
			acq_ch_d = '0;
		end
	end

	// channel registers; reset starts a full reload at once
	always_ff @(posedge sys_clk) begin
		if (soft_rst) begin
			hold_q <= {N_CH{`GDAC_MID_CODE}};
			out_q <= {N_CH{`GDAC_MID_CODE}};
			acq_q <= ACQ_READ;
			acq_all_q <= 1'b1;
			acq_ch_q <= '0;
			wait_q <= '0;
		end else begin
			hold_q <= hold_d;
			out_q <= out_d;
			acq_q <= acq_d;
			acq_all_q <= acq_all_d;
			acq_ch_q <= acq_ch_d;
			wait_q <= wait_d;
		end
	end

	assign dac_code = out_q;
	assign acq_busy = (acq_q != ACQ_IDLE);

	// nonvolatile store, read from the bank the pin selects
	gdac_nvm #(
		.WORDS(N_CH)
	) u_nvm (
		.sys_clk(sys_clk),
		.rst(rst),
		.rd_en(rd_en),
		.rd_bank(filt_q[S_BANK]),
		.rd_addr(acq_ch_q),
		.rd_q(rd_word),
		.wr(nvm_wr),
		.wr_refused(nvm_wr_refused)
	);

	a_addr_ack: assert property (@(posedge sys_clk) disable iff (soft_rst)
		(byte_done && bus_q == ST_ADDR && addr_hit && !shift_q[0] && !stop_det && !start_det)
		|=> sda_oe && bus_q == ST_PTR)
		else $error("own write address not acknowledged");
	a_ack_release: assert property (@(posedge sys_clk) disable iff (soft_rst)
		(ack_ph_q && scl_fall) |=> !sda_oe && cnt_q == 4'h0)
		else $error("data line held after the ninth clock");
	a_start_restart: assert property (@(posedge sys_clk) disable iff (soft_rst)
		start_det && !stop_det |=> bus_q == ST_ADDR && cnt_q == 4'h0 && !sda_oe)
		else $error("start condition not decoded");
	a_hs_no_ack: assert property (@(posedge sys_clk) disable iff (soft_rst)
		(byte_done && bus_q == ST_ADDR && shift_q[7:3] == `GDAC_HS_CODE && !start_det && !stop_det)
		|=> !sda_oe && hs_mode)
		else $error("master code acknowledged or high-speed not entered");
	a_hs_stop_exit: assert property (@(posedge sys_clk) disable iff (soft_rst)
		stop_det |=> !hs_mode)
		else $error("high-speed mode kept past stop");
	a_gcall_data: assert property (@(posedge sys_clk) disable iff (soft_rst)
		(byte_done && bus_q == ST_GCALL && shift_q != `GDAC_GCALL_RESET && !start_det && !stop_det)
		|=> !sda_oe)
		else $error("foreign general-call data acknowledged");
	a_gcall_reset: assert property (@(posedge sys_clk) disable iff (rst)
		(gc_arm_q && ack_ph_q && scl_fall && !start_det && !stop_det)
		|=> gc_rst_q ##1 (acq_q == ACQ_READ && dac_code == {N_CH{`GDAC_MID_CODE}}))
		else $error("general-call reset not performed");
	a_hold_only: assert property (@(posedge sys_clk) disable iff (soft_rst)
		(evt_wr && !evt_xfer && acq_q == ACQ_IDLE && !bank_chg) |=> $stable(dac_code))
		else $error("output changed on a holding write");
	a_xfer_all: assert property (@(posedge sys_clk) disable iff (soft_rst)
		(evt_xfer && acq_q != ACQ_LOAD) |=> dac_code == hold_q)
		else $error("outputs not transferred after bit sixteen");
	a_bank_reload: assert property (@(posedge sys_clk) disable iff (soft_rst)
		bank_chg |=> acq_q == ACQ_READ && acq_all_q && acq_ch_q == '0 ##1 acq_q == ACQ_LOAD)
		else $error("bank change did not start a reload");
	a_all_wait: assert property (@(posedge sys_clk) disable iff (soft_rst)
		(evt_all && acq_q == ACQ_IDLE && !bank_chg) |=> acq_q == ACQ_WAIT && wait_q == ALL_WAIT)
		else $error("general acquire delay not loaded");
	a_ptr_refuse: assert property (@(posedge sys_clk) disable iff (soft_rst)
		(byte_done && bus_q == ST_PTR && !ptr_ok && !start_det && !stop_det) |=> !sda_oe)
		else $error("invalid channel pointer acknowledged");
endmodule

// >>> rtl/gdac_nvm.sv
// two-bank nonvolatile channel store with per-entry programming counters
// assumes rst stands for power-on only; a soft reset of the controller must not reach it
`timescale 1ns/1ps
`include "gdac_params.svh"
module gdac_nvm
	import gdac_pkg::*;
#(
	parameter int WORDS = `GDAC_NUM_CH
) (
	// clock and power-on reset
	input wire logic sys_clk,
	input wire logic rst,
	// acquire read port, data one cycle after rd_en
	input wire logic rd_en,
	input wire logic rd_bank,
	input wire logic [`GDAC_PTR_W-1:0] rd_addr,
	output gdac_nvm_rd_s rd_q,
	// programming port
	input gdac_nvm_wr_s wr,
	output logic wr_refused
);
	localparam int ENT = 2 * WORDS;

	if (WORDS < 1 || WORDS > 63) begin : g_bad_words
		$error("gdac_nvm: WORDS out of range");
	end

	logic [`GDAC_CODE_W-1:0] code_q [ENT];
	logic prog_q [ENT];
	logic [4:0] cnt_q [ENT];
	logic [ENT-1:0] full;
	int wr_idx;
	int rd_idx;
	logic wr_ok;
	gdac_nvm_rd_s rd_d;
	logic refused_d;

	// entry index of each port: bank major, channel minor
	always_comb begin
		wr_idx = (wr.bank ? WORDS : 0) + int'(wr.addr);
		rd_idx = (rd_bank ? WORDS : 0) + int'(rd_addr);
		wr_ok = (int'(wr.addr) < WORDS) && !full[wr_idx % ENT];
		refused_d = wr.en && !wr_ok;
	end

	// one programmed word, its flag and its use count per entry
	for (genvar e = 0; e < ENT; e++) begin : g_ent
		logic hit;
		logic [`GDAC_CODE_W-1:0] code_d;
		logic prog_d;
		logic [4:0] cnt_d;
		assign full[e] = (cnt_q[e] == `GDAC_MAX_PROG);
		always_comb begin
			hit = wr.en && wr_ok && (wr_idx == e);
			code_d = hit ? wr.data : code_q[e];
			prog_d = hit | prog_q[e];
			cnt_d = hit ? cnt_q[e] + 5'h01 : cnt_q[e];
		end
		always_ff @(posedge sys_clk) begin
			if (rst) begin
				code_q[e] <= '0;
				prog_q[e] <= 1'b0;
				cnt_q[e] <= 5'h00;
			end else begin
				code_q[e] <= code_d;
				prog_q[e] <= prog_d;
				cnt_q[e] <= cnt_d;
			end
		end
	end

	// registered read, held between reads
	always_comb begin
		rd_d = rd_q;
		if (rd_en) begin
			rd_d.data = code_q[rd_idx % ENT];
			rd_d.prog = prog_q[rd_idx % ENT];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rd_q <= '0;
			wr_refused <= 1'b0;
		end else begin
			rd_q <= rd_d;
			wr_refused <= refused_d;
		end
	end

	a_prog_limit: assert property (@(posedge sys_clk) disable iff (rst)
		(wr.en && int'(wr.addr) < WORDS && full[wr_idx % ENT]) |=> wr_refused)
		else $error("programming past the limit was not refused");
endmodule

// >>> rtl/gdac_params.svh
// constants of the gamma dac two-wire control block: codes, field values, timing counts
// assumes inclusion by its bare name from the package and the design modules
`ifndef GDAC_PARAMS_SVH
`define GDAC_PARAMS_SVH
// channel layout
`define GDAC_NUM_CH 24
`define GDAC_CODE_W 10
`define GDAC_PTR_W 6
`define GDAC_MID_CODE 10'h200
// bus codes
`define GDAC_ADDR_HI 6'h3a
`define GDAC_GCALL_ADDR 8'h00
`define GDAC_GCALL_RESET 8'h06
`define GDAC_HS_CODE 5'h01
`define GDAC_BYTE_BITS 4'h8
// pointer command field, bits 7..6
`define GDAC_CMD_WRITE 2'h0
`define GDAC_CMD_ONE 2'h1
`define GDAC_CMD_ALL 2'h2
// msb data byte fields
`define GDAC_XFER_BIT 7
`define GDAC_NVM_TAG 2'h1
// nonvolatile programming limit per channel and bank
`define GDAC_MAX_PROG 5'h10
// timing
`define GDAC_CLK_MHZ 200
`define GDAC_ACQ_ALL_US 750
`define GDAC_ACQ_ONE_US 36
`define GDAC_ACQ_ALL_CYC (`GDAC_ACQ_ALL_US * `GDAC_CLK_MHZ)
`define GDAC_ACQ_ONE_CYC (`GDAC_ACQ_ONE_US * `GDAC_CLK_MHZ)
`define GDAC_WAIT_W 18
`endif

// >>> rtl/gdac_pkg.sv
// types shared by the gamma dac control block and its nonvolatile store
// assumes gdac_params.svh is on the include path
`include "gdac_params.svh"
package gdac_pkg;
	// two-wire receive phases
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_PTR = 3'h2,
		ST_MSB = 3'h3,
		ST_LSB = 3'h4,
		ST_GCALL = 3'h5,
		ST_SKIP = 3'h6
	} gdac_bus_e;
	// acquire sequencer
	typedef enum logic [1:0] {
		ACQ_IDLE = 2'h0,
		ACQ_WAIT = 2'h1,
		ACQ_READ = 2'h2,
		ACQ_LOAD = 2'h3
	} gdac_acq_e;
	// programming request into the store
	typedef struct packed {
		logic en;
		logic bank;
		logic [`GDAC_PTR_W-1:0] addr;
		logic [`GDAC_CODE_W-1:0] data;
	} gdac_nvm_wr_s;
	// word read from the store
	typedef struct packed {
		logic [`GDAC_CODE_W-1:0] data;
		logic prog;
	} gdac_nvm_rd_s;
endpackage

// >>> verification/gdac_bus_host.sv
// behavioural two-wire bus master: drives the clock pin and pulls the data wire low
// assumes sda_line is the resolved open-drain wire and sys_clk at 200 MHz; one bit lasts 16 cycles (80 ns)
`timescale 1ns/1ps
module gdac_bus_host (
	// clock
	input wire logic sys_clk,
	// resolved data wire
	input wire logic sda_line,
	// bus pins of the master
	output logic scl,
	output logic sda_low
);
	// idle bus: both lines released, clock stands still between frames
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// a quarter of one bit period
	task automatic qtr();
		repeat (4) @(posedge sys_clk);
	endtask
	// start or repeated start: data falls while the clock is high
	task automatic start();
		sda_low <= 1'b0;
		qtr();
		scl <= 1'b1;
		qtr();
		sda_low <= 1'b1;
		qtr();
		scl <= 1'b0;
		qtr();
	endtask
	// stop: data rises while the clock is high, then the bus rests
	task automatic stop();
		sda_low <= 1'b1;
		qtr();
		scl <= 1'b1;
		qtr();
		sda_low <= 1'b0;
		qtr();
	endtask
	// eight data bits, msb first, changed only while the clock is low, then the ack clock
	task automatic wbyte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_low <= ~b[i];
			qtr();
			scl <= 1'b1;
			qtr();
			qtr();
			scl <= 1'b0;
			qtr();
		end
		sda_low <= 1'b0;
		qtr();
		scl <= 1'b1;
		qtr();
		ack = ~sda_line;
		qtr();
		scl <= 1'b0;
		qtr();
	endtask
endmodule

// >>> verification/gdac_ctrl_tb.sv
// self-checking bench for the gamma dac two-wire control block
// assumes gdac_pkg and gdac_bus_host are compiled first; acquire delays are shortened by parameter
`timescale 1ns/1ps
module gdac_ctrl_tb;
	import gdac_pkg::*;
	localparam int ACQ_ALL = 200;
	localparam int ACQ_ONE = 20;
	localparam int SETTLE = 80;
	// clock, reset, pins and outputs
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic addr_strap_pin = 1'b0;
	logic bank_select_pin = 1'b0;
	logic scl, sda_low, sda_line, sda_out, sda_oe, hs_mode, acq_busy, nvm_wr_refused;
	gdac_nvm_wr_s nvm_wr = '0;
	logic [23:0][9:0] dac_code;
	// expected holding registers and output latches
	logic [9:0] hold [24];
	logic [9:0] out [24];
	int n_mismatch = 0;
	int check_count = 0;
	int cyc = 0;
	logic [15:0] rnd = 16'hf8e1;
	logic [9:0] va, vb, vc;
	logic [5:0] p;

	// 200 MHz clock
	always #2.5 sys_clk = ~sys_clk;
	// open-drain data wire with pull-up
	assign sda_line = ~(sda_low | (sda_oe & ~sda_out));

	gdac_ctrl #(.N_CH(24), .ACQ_ALL_CYC(ACQ_ALL), .ACQ_ONE_CYC(ACQ_ONE)) u_dut (
		.sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe(sda_oe), .addr_strap_pin(addr_strap_pin), .bank_select_pin(bank_select_pin),
		.nvm_wr(nvm_wr), .nvm_wr_refused(nvm_wr_refused), .dac_code(dac_code),
		.hs_mode(hs_mode), .acq_busy(acq_busy)
	);
	gdac_bus_host u_host (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

	// random source, fixed start value 63713
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// comparison with mismatch report
	task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// verdict and end of run
	task test_done();
		if (n_mismatch == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task settle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// one byte with the expected acknowledge
	task tx(input logic [7:0] b, input logic e);
		logic a;
		u_host.wbyte(b, a);
		chk("ack", {15'h0, a}, {15'h0, e});
	endtask
	// start, own address for write, pointer byte
	task open(input logic [7:0] ptr, input logic e);
		u_host.start();
		tx(8'he8, 1'b1);
		tx(ptr, e);
	endtask
	// msb then lsb of one channel; bit 15 moves every holding register to its output
	task wr(input logic [5:0] ch, input logic [9:0] d, input logic x);
		tx({x, 5'h00, d[9:8]}, 1'b1);
		tx(d[7:0], 1'b1);
		hold[ch] = d;
		if (x) begin
			out = hold;
		end
	endtask
	task cmp_all();
		for (int i = 0; i < 24; i++) begin
			chk("dac_code", {6'h0, dac_code[i]}, {6'h0, out[i]});
		end
	endtask
	// every channel back at mid-scale
	task blank();
		for (int i = 0; i < 24; i++) begin
			hold[i] = 10'h200;
			out[i] = 10'h200;
		end
	endtask
	// programming request at an edge, refusal pulse looked for over the next two cycles
	task prog(input logic bk, input logic [5:0] ad, input logic [9:0] d, input logic e);
		logic r;
		@(posedge sys_clk);
		nvm_wr <= '{en: 1'b1, bank: bk, addr: ad, data: d};
		@(posedge sys_clk);
		nvm_wr.en <= 1'b0;
		#1 r = nvm_wr_refused;
		@(posedge sys_clk);
		#1 r = r | nvm_wr_refused;
		chk("refused", {15'h0, r}, {15'h0, e});
		settle(1);
	endtask

	// hang guard
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_mismatch++;
			test_done();
		end
	end

	// main sequence
	initial begin
		blank();
		settle(8);
		rst <= 1'b0;
		settle(SETTLE);
		cmp_all();
		// addressing and refusals
		u_host.start();
		tx(8'hea, 1'b0);
		u_host.start();
		tx(8'he9, 1'b0);
		open(8'h18, 1'b0);
		open(8'h98, 1'b0);
		open(8'hc3, 1'b0);
		u_host.stop();
		addr_strap_pin <= 1'b1;
		settle(8);
		u_host.start();
		tx(8'hea, 1'b1);
		u_host.stop();
		addr_strap_pin <= 1'b0;
		settle(8);
		// high-speed entry, repeated start, exit at stop
		rnd = lfsr(rnd);
		u_host.start();
		tx({5'h01, rnd[2:0]}, 1'b0);
		chk("hs_mode", {15'h0, hs_mode}, 16'h1);
		open(8'h00, 1'b1);
		chk("hs_mode", {15'h0, hs_mode}, 16'h1);
		u_host.stop();
		settle(8);
		chk("hs_mode", {15'h0, hs_mode}, 16'h0);
		// random pairs: held write, then transfer of both with auto-increment
		for (int k = 0; k < 3; k++) begin
			rnd = lfsr(rnd);
			p = {1'b0, rnd[15:11] % 5'd23};
			va = rnd[9:0];
			rnd = lfsr(rnd);
			vb = rnd[9:0];
			open({2'b00, p}, 1'b1);
			wr(p, va, 1'b0);
			cmp_all();
			wr(p + 6'h1, vb, 1'b1);
			u_host.stop();
			cmp_all();
		end
		// programming-tagged pair is acked but not written, then lone msb with transfer bit
		open(8'h05, 1'b1);
		tx(8'h41, 1'b1);
		tx(8'h55, 1'b1);
		wr(6'h06, vb, 1'b1);
		tx(8'h83, 1'b1);
		u_host.stop();
		cmp_all();
		// general call: wrong data byte refused, reset code acknowledged
		u_host.start();
		tx(8'h00, 1'b1);
		tx(8'h07, 1'b0);
		u_host.stop();
		u_host.start();
		tx(8'h00, 1'b1);
		tx(8'h06, 1'b1);
		u_host.stop();
		settle(SETTLE);
		blank();
		cmp_all();
		// two banks, reload on every bank-select change
		vc = ~va;
		prog(1'b0, 6'h03, va, 1'b0);
		prog(1'b1, 6'h03, vb, 1'b0);
		bank_select_pin <= 1'b1;
		settle(SETTLE);
		hold[3] = vb;
		out[3] = vb;
		cmp_all();
		bank_select_pin <= 1'b0;
		settle(SETTLE);
		hold[3] = va;
		out[3] = va;
		cmp_all();
		// general acquire after the pin has rested
		settle(SETTLE);
		open(8'h03, 1'b1);
		wr(6'h03, vc, 1'b1);
		u_host.stop();
		open(8'h83, 1'b1);
		u_host.stop();
		chk("acq_busy", {15'h0, acq_busy}, 16'h1);
		settle(ACQ_ALL + SETTLE);
		blank();
		hold[3] = va;
		out[3] = va;
		cmp_all();
		chk("acq_busy", {15'h0, acq_busy}, 16'h0);
		// single acquire touches only its channel
		open(8'h03, 1'b1);
		wr(6'h03, vc, 1'b0);
		wr(6'h04, vc, 1'b1);
		u_host.stop();
		open(8'h43, 1'b1);
		u_host.stop();
		settle(ACQ_ONE + SETTLE);
		hold[3] = va;
		out[3] = va;
		cmp_all();
		// reset with bank one selected reloads from bank one
		bank_select_pin <= 1'b1;
		settle(SETTLE);
		u_host.start();
		tx(8'h00, 1'b1);
		tx(8'h06, 1'b1);
		u_host.stop();
		settle(SETTLE);
		blank();
		hold[3] = vb;
		out[3] = vb;
		cmp_all();
		// sixteen programming operations allowed, the next refused
		for (int k = 0; k < 16; k++) begin
			rnd = lfsr(rnd);
			prog(1'b0, 6'h07, rnd[9:0], 1'b0);
		end
		prog(1'b0, 6'h07, va, 1'b1);
		test_done();
	end
endmodule
